// ### rtl/reset_startup_status.sv
// Decided for this implementation: register access over AXI4-Lite.
`default_nettype none

module reset_startup_status #(
    parameter int POWER_UP_DELAY_TIMER_CYCLES = startup_pkg::POWER_UP_DELAY_TIMER_CYCLES
) (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    // Reset sources
    input  wire logic        POR_EVENT_I,
    input  wire logic        BROWNOUT_EVENT_I,
    input  wire logic        MASTER_CLEAR_EVENT_I,
    input  wire logic        WATCHDOG_TIMEOUT_I,
    input  wire logic        BROWN_OUT_ENABLE_FUSE_I,
    // Oscillator
    input  wire logic [1:0]  OSC_MODE_I,
    input  wire logic        OSC_PIN_PULSE_I,
    input  wire logic        OSC_AMPLITUDE_OK_I,
    // Core events
    input  wire logic        WATCHDOG_CLEAR_INSTR_I,
    input  wire logic        SLEEP_INSTR_I,
    input  wire logic [3:0]  STACK_PTR_I,
    input  wire logic        STACK_PUSH_I,
    input  wire logic [7:0]  INT_PENDING_I,
    input  wire logic [7:0]  INT_ENABLE_I,
    // AXI4-Lite write address
    input  wire logic [31:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire logic [31:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // Core control
    output logic             CORE_RESET_O,
    output logic             CORE_STALL_O,
    output logic             VECTOR_LOAD_O,
    output logic             INT_REQ_O,
    output logic [7:0]       DIRECTION_O
);
    import startup_pkg::*;

    // ========================================================
    // State
    // ========================================================
    seq_state_e  state_q;
    seq_state_e  state_d;
    logic [7:0]  status_q;
    logic [7:0]  status_d;
    logic [7:0]  dir_q;
    logic [7:0]  wake_flags_q;
    logic        power_up_delay_timer_done;
    logic        ost_done;
    logic        aw_have_q;
    logic        w_have_q;
    logic [31:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;

    // ========================================================
    // Reset sources and sequencing
    // ========================================================
    wire dev_reset_w = POR_EVENT_I | BROWNOUT_EVENT_I | MASTER_CLEAR_EVENT_I
                     | (WATCHDOG_TIMEOUT_I & (state_q != ST_SLEEP));
    wire int_hit_w   = |(INT_PENDING_I & INT_ENABLE_I);
    wire crystal_w   = (OSC_MODE_I == OSC_MODE_XT) || (OSC_MODE_I == OSC_MODE_LF);
    // Watchdog time-out in sleep only wakes the core
    wire wdt_wake_w  = WATCHDOG_TIMEOUT_I & (state_q == ST_SLEEP);
    wire wake_w      = (state_q == ST_SLEEP) & ~dev_reset_w & (int_hit_w | wdt_wake_w);
    wire ost_start_w = dev_reset_w | (wake_w & crystal_w);
    wire ost_inc_w   = OSC_PIN_PULSE_I & OSC_AMPLITUDE_OK_I;
    wire startup_ok_w = power_up_delay_timer_done & ost_done;

    // Power-up delay: started with every device reset
    startup_counter #(
        .W     (POWER_UP_DELAY_TIMER_CNT_W),
        .LIMIT (POWER_UP_DELAY_TIMER_CYCLES)
    ) u_power_up_delay_timer (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .start_i (dev_reset_w),
        .inc_i   (1'b1),
        .done_o  (power_up_delay_timer_done)
    );

    // Oscillator startup count, shared with the sleep wake path
    startup_counter #(
        .W     (OST_CNT_W),
        .LIMIT (OST_PERIODS)
    ) u_ost (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .start_i (ost_start_w),
        .inc_i   (ost_inc_w),
        .done_o  (ost_done)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RESET: begin
                if (startup_ok_w) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (SLEEP_INSTR_I) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_w) begin
                    state_d = crystal_w ? ST_WAKE : ST_RUN;
                end
            end
            ST_WAKE: begin
                if (ost_done && !ost_start_w) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
        if (dev_reset_w) begin
            state_d = ST_RESET;
        end
    end

    // ========================================================
    // Register bus decode
    // ========================================================
    wire [ADDR_W-1:0] wr_idx_w = aw_addr_q[ADDR_W+1:2];
    wire [ADDR_W-1:0] rd_idx_w = S_AXI_ARADDR[ADDR_W+1:2];
    wire wr_go_w      = aw_have_q & w_have_q & ~S_AXI_BVALID;
    wire wr_hit_w     = (aw_addr_q[31:ADDR_W+2] == '0);
    wire rd_hit_w     = (S_AXI_ARADDR[31:ADDR_W+2] == '0);
    wire wr_status_w  = wr_go_w & wr_hit_w & (wr_idx_w == IDX_CPU_STATUS) & w_strb_q[0];
    wire wr_dir_w     = wr_go_w & wr_hit_w & (wr_idx_w == IDX_DIRECTION) & w_strb_q[0];
    wire wr_flags_w   = wr_go_w & wr_hit_w & (wr_idx_w == IDX_WAKE_FLAGS) & w_strb_q[0];
    wire wr_mapped_w  = wr_hit_w & ((wr_idx_w == IDX_CPU_STATUS)
                      | (wr_idx_w == IDX_DIRECTION) | (wr_idx_w == IDX_SEQ_STATUS)
                      | (wr_idx_w == IDX_WAKE_FLAGS));
    wire rd_go_w      = S_AXI_ARVALID & S_AXI_ARREADY;
    wire [7:0] seq_w  = {4'h0, ost_done, power_up_delay_timer_done, state_q};
    wire [7:0] rd_byte_w =
          (rd_idx_w == IDX_CPU_STATUS) ? (status_q & STATUS_IMPL)
        : (rd_idx_w == IDX_DIRECTION)  ? dir_q
        : (rd_idx_w == IDX_SEQ_STATUS) ? seq_w
        : (rd_idx_w == IDX_WAKE_FLAGS) ? wake_flags_q
        : 8'h00;
    wire rd_mapped_w  = rd_hit_w & ((rd_idx_w == IDX_CPU_STATUS)
                      | (rd_idx_w == IDX_DIRECTION) | (rd_idx_w == IDX_SEQ_STATUS)
                      | (rd_idx_w == IDX_WAKE_FLAGS));

    // ========================================================
    // Status flags; hardware events win over software writes
    // ========================================================
    wire stack_full_w = (STACK_PTR_I == STACK_TOP)
                      | (STACK_PUSH_I & (STACK_PTR_I == STACK_TOP));
    wire [7:0] wdat_w = w_data_q[7:0];

    always_comb begin
        status_d = status_q;
        // Only interrupt disable, power-on and brown-out bits take writes
        if (wr_status_w) begin
            status_d[BIT_GLOBAL_INTERRUPT_DISABLE] = wdat_w[BIT_GLOBAL_INTERRUPT_DISABLE];
            status_d[BIT_POR]    = wdat_w[BIT_POR];
            status_d[BIT_BOR]    = wdat_w[BIT_BOR];
        end
        if (stack_full_w) begin
            status_d[BIT_STACK_AVAILABLE_FLAG] = 1'b0;
        end
        if (WATCHDOG_CLEAR_INSTR_I) begin
            status_d[BIT_TO] = 1'b1;
            status_d[BIT_PD] = 1'b1;
        end
        if (SLEEP_INSTR_I && state_q == ST_RUN) begin
            status_d[BIT_PD] = 1'b0;
        end
        if (WATCHDOG_TIMEOUT_I) begin
            status_d[BIT_TO] = 1'b0;
        end
        if (dev_reset_w) begin
            status_d[BIT_STACK_AVAILABLE_FLAG]  = 1'b1;
            status_d[BIT_GLOBAL_INTERRUPT_DISABLE] = 1'b1;
        end
        if (POR_EVENT_I) begin
            status_d[BIT_TO]  = 1'b1;
            status_d[BIT_PD]  = 1'b1;
            status_d[BIT_POR] = 1'b0;
        end
        if (BROWNOUT_EVENT_I && BROWN_OUT_ENABLE_FUSE_I) begin
            status_d[BIT_BOR] = 1'b0;
        end
        status_d = status_d & STATUS_IMPL;
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_q  <= ST_RESET;
            status_q <= STATUS_RESET;
        end else begin
            state_q  <= state_d;
            status_q <= status_d;
        end
    end

    // ========================================================
    // Direction and wake flag registers
    // ========================================================
    always_ff @(posedge CLK_I) begin
        if (RST_I || dev_reset_w) begin
            dir_q <= DIRECTION_RESET;
        end else if (wr_dir_w) begin
            dir_q <= wdat_w;
        end
    end

    // Only the flags that woke the core change on wake
    always_ff @(posedge CLK_I) begin
        if (RST_I || dev_reset_w) begin
            wake_flags_q <= WAKE_FLAGS_RST;
        end else begin
            wake_flags_q <= (wr_flags_w ? wdat_w : wake_flags_q)
                          | (wake_w ? (INT_PENDING_I & INT_ENABLE_I) : 8'h00);
        end
    end

    // ========================================================
    // Core control outputs
    // ========================================================
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            CORE_RESET_O  <= 1'b1;
            CORE_STALL_O  <= 1'b0;
            VECTOR_LOAD_O <= 1'b0;
            INT_REQ_O     <= 1'b0;
            DIRECTION_O   <= DIRECTION_RESET;
        end else begin
            CORE_RESET_O  <= (state_d == ST_RESET);
            CORE_STALL_O  <= (state_d == ST_SLEEP) | (state_d == ST_WAKE);
            // Vector pulsed on the interrupt wake event when interrupt disable is clear, while a crystal wake still stalls the core
            VECTOR_LOAD_O <= wake_w & int_hit_w & ~status_q[BIT_GLOBAL_INTERRUPT_DISABLE];
            INT_REQ_O     <= ~status_d[BIT_GLOBAL_INTERRUPT_DISABLE] & int_hit_w
                           & (state_d == ST_RUN);
            DIRECTION_O   <= dir_q;
        end
    end

    // ========================================================
    // AXI4-Lite write channel
    // ========================================================
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 32'h0000_0000;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have_q     <= 1'b1;
                aw_addr_q     <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have_q     <= 1'b1;
                w_data_q     <= S_AXI_WDATA;
                w_strb_q     <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_go_w) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_mapped_w ? RESP_OKAY : RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID  <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY  <= 1'b1;
            end
        end
    end

    // ========================================================
    // AXI4-Lite read channel
    // ========================================================
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= RESP_OKAY;
        end else if (rd_go_w) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= {24'h00_0000, rd_byte_w};
            S_AXI_RRESP   <= rd_mapped_w ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
        end
    end

endmodule : reset_startup_status

`default_nettype wire

// ### rtl/startup_pkg.sv
`default_nettype none

package startup_pkg;

    // ========================================================
    // Clock and timing
    // ========================================================
    localparam int CLK_PERIOD_PS    = 4000;
    localparam int POWER_UP_DELAY_TIMER_TIME_MS     = 96;
    localparam int POWER_UP_DELAY_TIMER_CYCLES      = (POWER_UP_DELAY_TIMER_TIME_MS * 1000000) / (CLK_PERIOD_PS / 1000);
    localparam int POWER_UP_DELAY_TIMER_CNT_W       = 25;
    localparam int OST_PERIODS      = 1024;
    localparam int OST_CNT_W        = 11;

    // ========================================================
    // Register indices; byte address is four times the index
    // ========================================================
    localparam logic [7:0] IDX_CPU_STATUS = 8'h06;
    localparam logic [7:0] IDX_DIRECTION  = 8'h07;
    localparam logic [7:0] IDX_SEQ_STATUS = 8'h08;
    localparam logic [7:0] IDX_WAKE_FLAGS = 8'h09;
    localparam int         ADDR_W         = 8;

    // ========================================================
    // Status register fields and reset value
    // ========================================================
    localparam int BIT_STACK_AVAILABLE_FLAG  = 5;
    localparam int BIT_GLOBAL_INTERRUPT_DISABLE = 4;
    localparam int BIT_TO     = 3;
    localparam int BIT_PD     = 2;
    localparam int BIT_POR    = 1;
    localparam int BIT_BOR    = 0;
    localparam logic [7:0] STATUS_RESET    = 8'h3D;
    localparam logic [7:0] STATUS_IMPL     = 8'h3F;
    localparam logic [7:0] DIRECTION_RESET = 8'hFF;
    localparam logic [7:0] WAKE_FLAGS_RST  = 8'h00;
    localparam logic [3:0] STACK_TOP       = 4'hF;

    // ========================================================
    // Oscillator modes and AXI responses
    // ========================================================
    localparam logic [1:0] OSC_MODE_LF = 2'h0;
    localparam logic [1:0] OSC_MODE_XT = 2'h1;
    localparam logic [1:0] OSC_MODE_EC = 2'h2;
    localparam logic [1:0] OSC_MODE_RC = 2'h3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_RESET  = 2'b00,
        ST_RUN    = 2'b01,
        ST_SLEEP  = 2'b10,
        ST_WAKE   = 2'b11
    } seq_state_e;

endpackage : startup_pkg

`default_nettype wire

// ### rtl/startup_counter.sv
`default_nettype none

module startup_counter #(
    parameter int W     = 11,
    parameter int LIMIT = 1024
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic start_i,
    input  wire logic inc_i,
    output logic      done_o
);

    // ========================================================
    // Counter runs from reset and stops at its limit
    // ========================================================
    logic [W-1:0] cnt_q;
    wire          last_w = (cnt_q == W'(LIMIT - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i || start_i) begin
            cnt_q  <= '0;
            done_o <= 1'b0;
        end else if (inc_i && !done_o) begin
            cnt_q  <= cnt_q + W'(1);
            done_o <= last_w;
        end
    end

endmodule : startup_counter

`default_nettype wire

// ### tb/reset_startup_status_properties.sv
`default_nettype none

module reset_startup_status_properties
    import startup_pkg::*;
#(
    parameter int POWER_UP_DELAY_TIMER_CYCLES = 50
) (
    // Clock, reset, events
    input wire logic        CLK_I,
    input wire logic        RST_I,
    input wire logic        POR_EVENT_I,
    input wire logic        BROWNOUT_EVENT_I,
    input wire logic        MASTER_CLEAR_EVENT_I,
    input wire logic        WATCHDOG_TIMEOUT_I,
    input wire logic        SLEEP_INSTR_I,
    // Oscillator and interrupts
    input wire logic        OSC_PIN_PULSE_I,
    input wire logic        OSC_AMPLITUDE_OK_I,
    input wire logic [7:0]  INT_PENDING_I,
    input wire logic [7:0]  INT_ENABLE_I,
    // Bus handshakes
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic        S_AXI_RVALID,
    input wire logic [31:0] S_AXI_RDATA,
    // Core control
    input wire logic        CORE_RESET_O,
    input wire logic        CORE_STALL_O,
    input wire logic        VECTOR_LOAD_O,
    input wire logic        INT_REQ_O,
    input wire logic [7:0]  DIRECTION_O
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Counts since the latest reset event
    // ==========
    // Watchdog resets do not clear these, so the bounds only get looser there
    logic [31:0] cyc_q;
    logic [11:0] qual_q;
    wire         any_rst = POR_EVENT_I | BROWNOUT_EVENT_I | MASTER_CLEAR_EVENT_I;
    wire         qual    = OSC_PIN_PULSE_I & OSC_AMPLITUDE_OK_I & ~&qual_q;

    always_ff @(posedge CLK_I) begin
        if (RST_I || any_rst) begin
            cyc_q  <= 32'h0;
            qual_q <= 12'h0;
        end else begin
            cyc_q  <= cyc_q + 32'h1;
            qual_q <= qual_q + {11'h0, qual};
        end
    end

    // ==========
    // Properties
    // ==========
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    sequence wr_both_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence sleep_in_run;
        SLEEP_INSTR_I && !any_rst && !WATCHDOG_TIMEOUT_I && !CORE_RESET_O && !CORE_STALL_O;
    endsequence

    hold_reset_a: assert property (any_rst |=> CORE_RESET_O [*2])
        else $error("core reset not held after reset event");
    power_up_delay_timer_count_a: assert property ($fell(CORE_RESET_O) |-> cyc_q >= POWER_UP_DELAY_TIMER_CYCLES)
        else $error("core left reset before power-up delay");
    ost_count_a: assert property ($fell(CORE_RESET_O) |-> qual_q >= 12'h400)
        else $error("core left reset before startup count");
    dir_reset_a: assert property (any_rst |-> ##2 DIRECTION_O == DIRECTION_RESET)
        else $error("direction not forced to inputs");
    int_gate_a: assert property (INT_REQ_O |-> $past(|(INT_PENDING_I & INT_ENABLE_I)))
        else $error("interrupt without enabled pending source");
    vec_pulse_a: assert property (VECTOR_LOAD_O |-> $past(CORE_STALL_O) ##1 !VECTOR_LOAD_O)
        else $error("vector load outside wake or too long");
    sleep_stall_a: assert property (sleep_in_run |=> CORE_STALL_O)
        else $error("sleep did not stall core");
    wr_answer_a: assert property (wr_both_taken |-> ##2 S_AXI_BVALID)
        else $error("write response late");
    rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
        S_AXI_RVALID && S_AXI_RDATA[31:8] == 24'h0) else $error("read answer wrong");
endmodule : reset_startup_status_properties

bind reset_startup_status reset_startup_status_properties #(
    .POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_CYCLES)
) u_props (.*);

`default_nettype wire

// ### tb/reset_startup_status_bench.sv
`default_nettype none

module reset_startup_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import startup_pkg::*;

    // ==========
    // Stimulus and observed signals
    // ==========
    logic CLK_I = 1'b0, RST_I = 1'b1, POR_EVENT_I = 1'b0, BROWNOUT_EVENT_I = 1'b0;
    logic MASTER_CLEAR_EVENT_I = 1'b0, WATCHDOG_TIMEOUT_I = 1'b0, BROWN_OUT_ENABLE_FUSE_I = 1'b0;
    logic [1:0] OSC_MODE_I = OSC_MODE_XT;
    logic OSC_PIN_PULSE_I = 1'b0, OSC_AMPLITUDE_OK_I = 1'b0, WATCHDOG_CLEAR_INSTR_I = 1'b0;
    logic SLEEP_INSTR_I = 1'b0, STACK_PUSH_I = 1'b0;
    logic [3:0] STACK_PTR_I = 4'h0, S_AXI_WSTRB = 4'hF;
    logic [7:0] INT_PENDING_I = 8'h00, INT_ENABLE_I = 8'h03, DIRECTION_O;
    logic [31:0] S_AXI_AWADDR = 32'h0, S_AXI_WDATA = 32'h0, S_AXI_ARADDR = 32'h0, S_AXI_RDATA;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic CORE_RESET_O, CORE_STALL_O, VECTOR_LOAD_O, INT_REQ_O;
    int   n_mismatch = 0;
    int   n_checks   = 0;

    localparam logic [31:0] A_ST   = {22'h0, IDX_CPU_STATUS, 2'h0};
    localparam logic [31:0] A_DIR  = {22'h0, IDX_DIRECTION, 2'h0};
    localparam logic [31:0] A_WAKE = {22'h0, IDX_WAKE_FLAGS, 2'h0};
    localparam logic [31:0] A_BAD  = 32'h40;

    // Short power-up delay keeps the run brief
    reset_startup_status #(.POWER_UP_DELAY_TIMER_CYCLES(50)) u_dut (.*);

    always #2 CLK_I = ~CLK_I;
    // One qualified pulse every two cycles while amplitude is good
    always @(posedge CLK_I) OSC_PIN_PULSE_I <= ~OSC_PIN_PULSE_I;

    // ==========
    // Common tasks
    // ==========
    task automatic complete_run;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    task automatic hang;
        n_mismatch++;
        $display("[FAIL] %0t wait ran out", $time);
        complete_run();
    endtask : hang

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic fire(input int k);
        POR_EVENT_I            <= (k == 0);
        BROWNOUT_EVENT_I       <= (k == 1);
        MASTER_CLEAR_EVENT_I   <= (k == 2);
        WATCHDOG_TIMEOUT_I     <= (k == 3);
        WATCHDOG_CLEAR_INSTR_I <= (k == 4);
        SLEEP_INSTR_I          <= (k == 5);
        @(posedge CLK_I);
        {POR_EVENT_I, BROWNOUT_EVENT_I, MASTER_CLEAR_EVENT_I} <= 3'h0;
        {WATCHDOG_TIMEOUT_I, WATCHDOG_CLEAR_INSTR_I, SLEEP_INSTR_I} <= 3'h0;
        @(posedge CLK_I);
    endtask : fire

    task automatic wait_run(output int n);
        n = 0;
        while ((CORE_RESET_O !== 1'b0 || CORE_STALL_O !== 1'b0) && n < 5000) begin
            @(posedge CLK_I);
            n++;
        end
        if (n >= 5000) hang();
    endtask : wait_run

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        int   n;
        logic got;
        n   = 0;
        got = 1'b0;
        S_AXI_AWADDR  <= a;
        S_AXI_WDATA   <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID  <= 1'b1;
        S_AXI_BREADY  <= 1'b1;
        while (got !== 1'b1 && n < 200) begin
            @(posedge CLK_I);
            n++;
            if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
            got = S_AXI_BVALID;
        end
        if (got !== 1'b1) hang();
        check({30'h0, S_AXI_BRESP}, {30'h0, er});
    endtask : wr

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
        int   n;
        logic got;
        n   = 0;
        got = 1'b0;
        S_AXI_ARADDR  <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY  <= 1'b1;
        while (got !== 1'b1 && n < 200) begin
            @(posedge CLK_I);
            n++;
            if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
            got = S_AXI_RVALID;
        end
        if (got !== 1'b1) hang();
        check(S_AXI_RDATA, exp);
        check({30'h0, S_AXI_RRESP}, {30'h0, er});
    endtask : rd_chk

    // ==========
    // Scenarios
    // ==========
    task automatic scn_boot;
        int n;
        repeat (100) @(posedge CLK_I);
        check({31'h0, CORE_RESET_O}, 32'h1);
        OSC_AMPLITUDE_OK_I <= 1'b1;
        wait_run(n);
        check({31'h0, n >= 2040}, 32'h1);
        rd_chk(A_ST, 32'h3D, RESP_OKAY);
        rd_chk(A_DIR, 32'hFF, RESP_OKAY);
    endtask : scn_boot

    task automatic scn_regs;
        wr(A_ST, 32'hFF, RESP_OKAY);
        rd_chk(A_ST, 32'h3F, RESP_OKAY);
        wr(A_ST, 32'h00, RESP_OKAY);
        rd_chk(A_ST, 32'h2C, RESP_OKAY);
        wr(A_BAD, 32'h55, RESP_SLVERR);
        rd_chk(A_BAD, 32'h0, RESP_SLVERR);
        wr(A_DIR, 32'h5A, RESP_OKAY);
        rd_chk(A_DIR, 32'h5A, RESP_OKAY);
        S_AXI_WSTRB <= 4'h0;
        wr(A_DIR, 32'h33, RESP_OKAY);
        S_AXI_WSTRB <= 4'hF;
        rd_chk(A_DIR, 32'h5A, RESP_OKAY);
        check({24'h0, DIRECTION_O}, 32'h5A);
        STACK_PTR_I <= STACK_TOP;
        @(posedge CLK_I);
        STACK_PTR_I <= 4'h3;
        rd_chk(A_ST, 32'h0C, RESP_OKAY);
        wr(A_ST, 32'h20, RESP_OKAY);
        rd_chk(A_ST, 32'h0C, RESP_OKAY);
    endtask : scn_regs

    task automatic scn_intreq;
        INT_PENDING_I <= 8'h01;
        repeat (3) @(posedge CLK_I);
        check({31'h0, INT_REQ_O}, 32'h1);
        wr(A_ST, 32'h10, RESP_OKAY);
        repeat (3) @(posedge CLK_I);
        check({31'h0, INT_REQ_O}, 32'h0);
        wr(A_ST, 32'h00, RESP_OKAY);
        INT_PENDING_I <= 8'h04;
        repeat (3) @(posedge CLK_I);
        check({31'h0, INT_REQ_O}, 32'h0);
        INT_PENDING_I <= 8'h00;
    endtask : scn_intreq

    task automatic scn_sleep;
        int n;
        fire(5);
        rd_chk(A_ST, 32'h08, RESP_OKAY);
        INT_PENDING_I <= 8'h02;
        n = 0;
        while (VECTOR_LOAD_O !== 1'b1 && n < 20) begin
            @(posedge CLK_I);
            n++;
        end
        if (n >= 20) hang();
        INT_PENDING_I <= 8'h00;
        check({31'h0, n < 20}, 32'h1);
        check({31'h0, CORE_STALL_O}, 32'h1);
        wait_run(n);
        check({31'h0, n >= 2040}, 32'h1);
        rd_chk(A_DIR, 32'h5A, RESP_OKAY);
        rd_chk(A_WAKE, 32'h02, RESP_OKAY);
        // Non-crystal wake skips the startup count
        OSC_MODE_I <= OSC_MODE_RC;
        fire(5);
        INT_PENDING_I <= 8'h02;
        wait_run(n);
        INT_PENDING_I <= 8'h00;
        check({31'h0, n < 8}, 32'h1);
        check({31'h0, VECTOR_LOAD_O}, 32'h1);
        OSC_MODE_I <= OSC_MODE_XT;
        fire(4);
        rd_chk(A_ST, 32'h0C, RESP_OKAY);
    endtask : scn_sleep

    task automatic scn_resets;
        logic [7:0] exp [4] = '{8'h3D, 8'h3E, 8'h3F, 8'h37};
        int         n;
        BROWN_OUT_ENABLE_FUSE_I <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr(A_ST, 32'h03, RESP_OKAY);
            wr(A_DIR, 32'h5A, RESP_OKAY);
            fire(k);
            wait_run(n);
            rd_chk(A_ST, {24'h0, exp[k]}, RESP_OKAY);
            rd_chk(A_DIR, 32'hFF, RESP_OKAY);
        end
        fire(4);
        rd_chk(A_ST, 32'h3F, RESP_OKAY);
    endtask : scn_resets

    initial begin
        repeat (20) @(posedge CLK_I);
        RST_I <= 1'b0;
        @(posedge CLK_I);
        scn_boot();
        scn_regs();
        scn_intreq();
        scn_sleep();
        scn_resets();
        complete_run();
    end
endmodule : reset_startup_status_bench

`default_nettype wire
